// ---- sim/rsc_far_side.sv ----
// far-side model: reset pin, fault detectors and flash requester
`timescale 1ns/10ps
`include "rsc_defines.svh"
module rsc_far_side (
    // clock
    input wire logic clock,
    // reset sources
    output logic reset_pin_n,
    output logic clock_loss_timeout,
    output logic comparator_below,
    output logic supply_monitor_low,
    // flash access
    output logic flash_req,
    output logic [1:0] flash_kind,
    output logic [15:0] flash_addr,
    output logic flash_secure_deny,
    output logic program_store_write_enable,
    output logic supply_monitor_level_select
);
    // ==========================================
    // idle levels
    initial begin
        {clock_loss_timeout, comparator_below, supply_monitor_low, flash_req} = 4'h0;
        reset_pin_n = 1'b1;
        {flash_kind, flash_addr, flash_secure_deny, program_store_write_enable} = 20'h0;
        supply_monitor_level_select = 1'b1;
    end
    // ==========================================
    // sources {pin, clock loss, comparator, supply} asserted for n cycles
    // comparator only toggles once settled, no chatter
    task pulse(input logic [3:0] w, input int n);
        @(posedge clock);
        {reset_pin_n, clock_loss_timeout, comparator_below, supply_monitor_low} <= {~w[3], w[2:0]};
        repeat (n) @(posedge clock);
        {reset_pin_n, clock_loss_timeout, comparator_below, supply_monitor_low} <= 4'h8; // pull-up on pin
    endtask
    // ==========================================
    // one flash access; address and deny flip afterwards so stale values never look valid
    task flash(input logic [1:0] k, input logic [15:0] a, input logic deny);
        @(posedge clock);
        flash_req <= 1'b1;
        flash_kind <= k;
        flash_addr <= a;
        flash_secure_deny <= deny;
        program_store_write_enable <= (k == `RSC_FL_WRITE);
        @(posedge clock);
        flash_req <= 1'b0;
        flash_addr <= ~a;
        flash_secure_deny <= ~deny;
    endtask
endmodule // rsc_far_side

// ---- sim/rsc_top_test.sv ----
// self-checking bench of the reset source controller
`timescale 1ns/10ps
`include "rsc_defines.svh"
module rsc_top_test;
    // ==========================================
    // signals
    localparam logic [11:0] A_CAUSE = {2'h0, `RSC_IDX_CAUSE, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, `RSC_IDX_STATUS, 2'h0};
    localparam logic [11:0] A_MASK = {2'h0, `RSC_IDX_MASK, 2'h0};
    localparam logic [11:0] A_WDOG = {2'h0, `RSC_IDX_WDOG, 2'h0};
    localparam logic [11:0] A_ENAB = {2'h0, `RSC_IDX_ENABLE, 2'h0};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, reset_pin_n, clock_loss_timeout, comparator_below, supply_monitor_low;
    logic flash_req, flash_secure_deny, program_store_write_enable, supply_monitor_level_select;
    logic sys_reset, irq;
    logic [1:0] flash_kind;
    logic [15:0] flash_addr;
    // note: {check data, expected error, expected byte}
    logic [9:0] q[$];
    logic [9:0] got;
    logic [7:0] v;
    integer err_count = 0;
    integer checked = 0;
    integer seed = 32'hFCEF;
    integer i, n;
    always #12.5 clock = ~clock;
    rsc_top u_rsc_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .reset_pin_n, .clock_loss_timeout, .comparator_below, .supply_monitor_low, .flash_req,
        .flash_kind, .flash_addr, .flash_secure_deny, .program_store_write_enable,
        .supply_monitor_level_select, .sys_reset, .irq);
    rsc_far_side u_rsc_far_side (.clock, .reset_pin_n, .clock_loss_timeout, .comparator_below,
        .supply_monitor_low, .flash_req, .flash_kind, .flash_addr, .flash_secure_deny,
        .program_store_write_enable, .supply_monitor_level_select);
    // ==========================================
    // helpers
    task test_done;
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic c, input string s);
        checked++;
        if (c !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, s);
        end
    endtask
    // one transfer; upper data bits random since only the low byte counts
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [9:0] e);
        @(posedge clock);
        {psel, penable, pwrite, paddr} <= {2'b10, w, a};
        pwdata <= {24'($random(seed)), d};
        q.push_back(e);
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            chk(1'b0, "no answer");
            test_done;
        end
    endtask
    // waits for a system reset to start and finish
    task wait_rst;
        for (n = 0; sys_reset !== 1'b1 && n < 60; n++) @(posedge clock);
        if (sys_reset !== 1'b1) begin
            chk(1'b0, "reset missing");
            test_done;
        end
        for (n = 0; sys_reset !== 1'b0 && n < 400; n++) @(posedge clock);
        if (sys_reset !== 1'b0) begin
            chk(1'b0, "reset hang");
            test_done;
        end
    endtask
    task quiet;
        repeat (30) begin
            @(posedge clock);
            chk(sys_reset === 1'b0, "unexpected reset");
        end
    endtask
    // ==========================================
    // answer monitor
    always @(posedge clock) begin
        if (pready === 1'b1) begin
            if (q.size() == 0) begin
                chk(1'b0, "unexpected answer");
            end else begin
                got = q.pop_front();
                chk(pslverr === got[8], "error response");
                if (got[9]) chk(prdata === {24'h0, got[7:0]}, "read data");
            end
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        wait_rst;
        apb(1'b0, A_CAUSE, 8'h0, 10'h202);
        apb(1'b0, A_STAT, 8'h0, 10'h202);
        apb(1'b0, A_ENAB, 8'h0, 10'h201);
        apb(1'b0, A_WDOG, 8'h0, 10'h201);
        apb(1'b1, A_WDOG, 8'h03, 10'h000);
        apb(1'b0, 12'h3D0, 8'h0, 10'h300);
        v = 8'($random(seed)) & 8'h7F;
        apb(1'b1, A_MASK, v, 10'h000);
        pstrb <= 4'hE;
        apb(1'b1, A_MASK, ~v, 10'h000);
        pstrb <= 4'hF;
        apb(1'b0, A_MASK, 8'h0, {2'b10, v});
        apb(1'b1, A_MASK, 8'h00, 10'h000);
        apb(1'b1, A_CAUSE, 8'h48, 10'h000);
        apb(1'b0, A_CAUSE, 8'h0, 10'h202);
        u_rsc_far_side.pulse(4'b0110, 4);
        quiet;
        u_rsc_far_side.flash(`RSC_FL_FETCH, 16'hFBFF, 1'b0);
        quiet;
        apb(1'b1, A_CAUSE, 8'h06, 10'h000);
        apb(1'b0, A_ENAB, 8'h0, 10'h203);
        apb(1'b1, A_CAUSE, 8'h02, 10'h000);
        apb(1'b0, A_ENAB, 8'h0, 10'h201);
        u_rsc_far_side.pulse(4'b0100, 4);
        quiet;
        apb(1'b1, A_WDOG, 8'h00, 10'h000);
        apb(1'b0, A_WDOG, 8'h0, 10'h200);
        for (i = 0; i < 8; i++) begin
            case (i)
                0: apb(1'b1, A_CAUSE, 8'h10, 10'h000);
                1: u_rsc_far_side.pulse(4'b1000, 10);
                2: u_rsc_far_side.pulse(4'b0001, 4);
                3: apb(1'b1, A_CAUSE, 8'h04, 10'h000);
                4: apb(1'b1, A_CAUSE, 8'h20, 10'h000);
                5: u_rsc_far_side.flash(`RSC_FL_FETCH, `RSC_FL_RESERVED, 1'b0);
                6: u_rsc_far_side.flash(`RSC_FL_READ, 16'h1234, 1'b1);
                default: u_rsc_far_side.flash(`RSC_FL_WRITE, `RSC_FL_RESERVED, 1'b0);
            endcase
            if (i == 3) u_rsc_far_side.pulse(4'b0100, 4);
            if (i == 4) u_rsc_far_side.pulse(4'b0010, 4);
            v = (i < 5) ? 8'({8'h10, 8'h01, 8'h02, 8'h04, 8'h20} >> (8 * (4 - i))) : 8'h40;
            wait_rst;
            apb(1'b0, A_CAUSE, 8'h0, {2'b10, v});
            apb(1'b0, A_ENAB, 8'h0, 10'h201);
            apb(1'b0, A_WDOG, 8'h0, 10'h201);
            repeat (3) @(posedge clock);
            chk(irq === 1'b0, "irq while masked");
            apb(1'b1, A_MASK, v, 10'h000);
            repeat (3) @(posedge clock);
            chk(irq === 1'b1, "irq missing");
            apb(1'b0, A_STAT, 8'h0, {2'b10, v});
            repeat (3) @(posedge clock);
            chk(irq === 1'b0, "irq after clear");
            apb(1'b1, A_MASK, 8'h00, 10'h000);
        end
        test_done;
    end
endmodule // rsc_top_test

// ---- src/rsc_defines.svh ----
// register offsets, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
// ==========================================
// register indices (byte address = 4 * index)
`define RSC_IDX_CAUSE 8'hEF
`define RSC_IDX_STATUS 8'hF0
`define RSC_IDX_MASK 8'hF1
`define RSC_IDX_WDOG 8'hF2
`define RSC_IDX_ENABLE 8'hF3
// ==========================================
// reset-cause register fields
`define RSC_BIT_PIN 0
`define RSC_BIT_POR 1
`define RSC_BIT_MCD 2
`define RSC_BIT_WDT 3
`define RSC_BIT_SW 4
`define RSC_BIT_COMP 5
`define RSC_BIT_FERR 6
`define RSC_CAUSE_POR 7'h02
`define RSC_CAUSE_NONE 7'h00
// ==========================================
// watchdog control fields
`define RSC_WDOG_EN 0
`define RSC_WDOG_KICK 1
// ==========================================
// flash access kinds and start of reserved space
`define RSC_FL_WRITE 2'h0
`define RSC_FL_READ 2'h1
`define RSC_FL_FETCH 2'h2
`define RSC_FL_RESERVED 16'hFC00
// ==========================================
// timing counts
`define RSC_HOLD_CYCLES 5'h10
`define RSC_WDT_DIV 4'hC
`define RSC_WDT_LIMIT 16'hFFFF
`endif

// ---- src/rsc_pkg.sv ----
// types of the reset source controller
package rsc_pkg;
    // ==========================================
    // sequencer states
    typedef enum logic [2:0] {
        RSC_RUN = 3'b001,
        RSC_PIN = 3'b010,
        RSC_HOLD = 3'b100
    } rsc_state_t;
endpackage

// ---- src/rsc_top.sv ----
// reset source controller: cause register, watchdog, source gating and apb slave
//
// Operation
// - low level on reset pin resets device; pin flag set on exit
// - clock-loss one-shot timeout forces system reset
// - bit 2 flags clock-loss reset; writing it enables or disables detector
// - internal resets assert only system reset, never drive the pin
// - bit 5 write enables comparator reset when input below reference
// - bit 5 reads 1 only after comparator reset
// - watchdog enabled, clocked at clock/12 after any reset; overflow resets
// - bit 3 read-only, set after watchdog overflow reset
// - flash access at or above reserved space raises reset
// - forbidden or unsupplied flash access other than a fetch raises flash-error reset
// - bit 6 read-only, set after flash-error reset
// - writing 1 to bit 4 forces reset; bit reads 1 afterwards
// - bit 1 write enables supply monitor; reads 1 after power-on/monitor reset
// - power-on flag set means other flags indeterminate
`timescale 1ns/10ps
`include "rsc_defines.svh"

module rsc_top
    import rsc_pkg::*;
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous reset sources
    input wire logic reset_pin_n,
    input wire logic clock_loss_timeout,
    input wire logic comparator_below,
    input wire logic supply_monitor_low,
    // flash access checker
    input wire logic flash_req,
    input wire logic [1:0] flash_kind,
    input wire logic [15:0] flash_addr,
    input wire logic flash_secure_deny,
    input wire logic program_store_write_enable,
    input wire logic supply_monitor_level_select,
    // outputs
    output logic sys_reset,
    output logic irq
);

    // ==========================================
    // synchronisers
    logic [3:0] sync1;
    logic [3:0] sync2;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1 <= 4'h1;
            sync2 <= 4'h1;
        end else begin
            sync1 <= {supply_monitor_low, comparator_below, clock_loss_timeout, reset_pin_n};
            sync2 <= sync1;
        end
    end
    logic pin_n_s, mcd_s, comp_s, vdd_s;
    assign pin_n_s = sync2[0];
    assign mcd_s = sync2[1];
    assign comp_s = sync2[2];
    assign vdd_s = sync2[3];

    // ==========================================
    // apb decode
    logic [5:0] sel;
    logic acc, wr, rd;
    assign sel[0] = paddr == {2'h0, `RSC_IDX_CAUSE, 2'h0};
    assign sel[1] = paddr == {2'h0, `RSC_IDX_STATUS, 2'h0};
    assign sel[2] = paddr == {2'h0, `RSC_IDX_MASK, 2'h0};
    assign sel[3] = paddr == {2'h0, `RSC_IDX_WDOG, 2'h0};
    assign sel[4] = paddr == {2'h0, `RSC_IDX_ENABLE, 2'h0};
    assign sel[5] = ~|sel[4:0];
    // effects land only on the edge that samples pready high
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite & pstrb[0];
    assign rd = acc & ~pwrite;

    // ==========================================
    // state and cause registers
    rsc_state_t state;
    logic [6:0] cause;
    logic [6:0] pending;
    logic [4:0] hold_cnt;
    logic mcd_en, comp_en, vdd_en;
    logic wdt_en, wdt_ovf;
    logic [6:0] status, mask;
    logic flash_err;
    logic [6:0] req;
    logic [6:0] next_pending;
    logic exit_reset;

    // flash checks; an unsupplied or secured access other than a fetch counts like an illegal address
    always_comb begin
        flash_err = 1'b0;
        if (flash_req) begin
            unique case (flash_kind)
                `RSC_FL_WRITE: flash_err = program_store_write_enable
                    & (flash_addr >= `RSC_FL_RESERVED);
                `RSC_FL_READ, `RSC_FL_FETCH: flash_err = flash_addr >= `RSC_FL_RESERVED;
                default: flash_err = 1'b0;
            endcase
            if (flash_kind != `RSC_FL_FETCH
                && (flash_kind != `RSC_FL_WRITE || program_store_write_enable)
                && (flash_secure_deny || !(supply_monitor_level_select && vdd_en))) begin
                flash_err = 1'b1;
            end
        end
    end

    // request vector laid out like the cause register
    always_comb begin
        req = `RSC_CAUSE_NONE;
        req[`RSC_BIT_PIN] = ~pin_n_s;
        req[`RSC_BIT_POR] = vdd_en & vdd_s;
        req[`RSC_BIT_MCD] = mcd_en & mcd_s;
        req[`RSC_BIT_WDT] = wdt_ovf;
        req[`RSC_BIT_SW] = wr & sel[0] & pwdata[`RSC_BIT_SW];
        req[`RSC_BIT_COMP] = comp_en & comp_s;
        req[`RSC_BIT_FERR] = flash_err;
        // lowest bit wins so only one cause is ever recorded
        next_pending = req & (~req + 7'h01);
    end

    assign exit_reset = state == RSC_HOLD && hold_cnt == `RSC_HOLD_CYCLES;

    // ==========================================
    // sequencer; sys_reset is the only output, the pin is never driven
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= RSC_HOLD;
            sys_reset <= 1'b1;
            pending <= `RSC_CAUSE_POR;
            hold_cnt <= 5'h00;
        end else begin
            unique case (state)
                RSC_RUN: begin
                    if (|req) begin
                        pending <= next_pending;
                        sys_reset <= 1'b1;
                        hold_cnt <= 5'h00;
                        state <= req[`RSC_BIT_PIN] ? RSC_PIN : RSC_HOLD;
                    end
                end
                RSC_PIN: begin
                    if (pin_n_s) begin
                        state <= RSC_HOLD;
                    end
                end
                RSC_HOLD: begin
                    hold_cnt <= hold_cnt + 5'h01;
                    if (!pin_n_s) begin
                        state <= RSC_PIN;
                        pending <= 7'h01;
                        hold_cnt <= 5'h00;
                    end else if (exit_reset) begin
                        sys_reset <= 1'b0;
                        state <= RSC_RUN;
                    end
                end
            endcase
        end
    end

    // cause flags change only on leaving reset; power-on shows alone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cause <= `RSC_CAUSE_POR;
        end else if (exit_reset && pin_n_s) begin
            cause <= pending;
        end
    end

    // source enables; resets clear mcd_en and comp_en so a stale source cannot loop, and set vdd_en
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mcd_en <= 1'b0;
            comp_en <= 1'b0;
            vdd_en <= 1'b1;
        end else if (sys_reset) begin
            mcd_en <= 1'b0;
            comp_en <= 1'b0;
            vdd_en <= 1'b1;
        end else if (wr && sel[0]) begin
            mcd_en <= pwdata[`RSC_BIT_MCD];
            comp_en <= pwdata[`RSC_BIT_COMP] | comp_en;
            vdd_en <= pwdata[`RSC_BIT_POR] | vdd_en;
        end
    end

    // ==========================================
    // watchdog at clock/12, re-armed by every reset
    logic [3:0] wdt_pre;
    logic [15:0] wdt_cnt;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wdt_en <= 1'b1;
            wdt_pre <= 4'h0;
            wdt_cnt <= 16'h0000;
            wdt_ovf <= 1'b0;
        end else if (sys_reset) begin
            wdt_en <= 1'b1;
            wdt_pre <= 4'h0;
            wdt_cnt <= 16'h0000;
            wdt_ovf <= 1'b0;
        end else begin
            wdt_ovf <= 1'b0;
            if (wr && sel[3]) begin
                wdt_en <= pwdata[`RSC_WDOG_EN];
            end
            if (wr && sel[3] && pwdata[`RSC_WDOG_KICK]) begin
                wdt_cnt <= 16'h0000;
                wdt_pre <= 4'h0;
            end else if (wdt_en) begin
                wdt_pre <= (wdt_pre == `RSC_WDT_DIV - 4'h1) ? 4'h0 : wdt_pre + 4'h1;
                if (wdt_pre == `RSC_WDT_DIV - 4'h1) begin
                    if (wdt_cnt == `RSC_WDT_LIMIT) begin
                        wdt_ovf <= 1'b1;
                    end
                    wdt_cnt <= wdt_cnt + 16'h0001;
                end
            end
        end
    end

    // ==========================================
    // sticky event status, read clears, set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status <= `RSC_CAUSE_NONE;
            mask <= `RSC_CAUSE_NONE;
            irq <= 1'b0;
        end else begin
            status <= ((rd && sel[1]) ? `RSC_CAUSE_NONE : status)
                | ((exit_reset && pin_n_s) ? pending : `RSC_CAUSE_NONE);
            if (wr && sel[2]) begin
                mask <= pwdata[6:0];
            end
            irq <= |(status & mask);
        end
    end

    // ==========================================
    // apb answer: one wait state, unmapped gives an error and zero data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & sel[5];
            prdata <= 32'h00000000;
            if (psel && penable && !pready && !pwrite) begin
                unique case (1'b1)
                    sel[0]: prdata <= {25'h0, cause};
                    sel[1]: prdata <= {25'h0, status};
                    sel[2]: prdata <= {25'h0, mask};
                    sel[3]: prdata <= {31'h0, wdt_en};
                    sel[4]: prdata <= {29'h0, comp_en, mcd_en, vdd_en};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================
    // assertions
    a_pin_enters: assert property (@(posedge clock) disable iff (rst)
        (state == RSC_RUN && !pin_n_s) |=> sys_reset && state == RSC_PIN)
        else $error("pin low did not reset");
    a_pin_stays: assert property (@(posedge clock) disable iff (rst)
        !pin_n_s |=> sys_reset)
        else $error("reset released while pin low");
    a_mcd_gate: assert property (@(posedge clock) disable iff (rst)
        (state == RSC_RUN && mcd_en && mcd_s) |=> sys_reset ##[1:40] (!sys_reset || !pin_n_s))
        else $error("clock loss reset wrong");
    a_cause_onehot: assert property (@(posedge clock) disable iff (rst)
        $fell(sys_reset) |-> $onehot(cause))
        else $error("cause not one-hot");
    a_sw_force: assert property (@(posedge clock) disable iff (rst)
        (state == RSC_RUN && req == 7'h10) |=> sys_reset ##[16:17] (!sys_reset && cause[`RSC_BIT_SW]))
        else $error("software reset not flagged");
    a_comp_flag: assert property (@(posedge clock) disable iff (rst)
        $fell(sys_reset) && $past(pending) == 7'h20 |-> cause == 7'h20)
        else $error("comparator flag wrong");
    a_wdt_rearm: assert property (@(posedge clock) disable iff (rst)
        $fell(sys_reset) |-> wdt_en && wdt_cnt == 16'h0000)
        else $error("watchdog not armed after reset");
    a_wdt_div: assert property (@(posedge clock) disable iff (rst)
        wdt_pre < `RSC_WDT_DIV)
        else $error("watchdog prescaler out of range");
    a_flash_reset: assert property (@(posedge clock) disable iff (rst)
        (state == RSC_RUN && flash_err) |=> sys_reset)
        else $error("flash error did not reset");
    a_hold_len: assert property (@(posedge clock) disable iff (rst)
        $rose(sys_reset) && pin_n_s |-> sys_reset [*8])
        else $error("reset pulse too short");

endmodule // rsc_top
